// ### rtl/tmr_pkg.sv
package tmr_pkg;
    localparam logic [7:0] timer_count_addr  = 8'h01;
    localparam logic [5:0] timer_config_rst  = 6'h3f;
    localparam int         clock_source_bit  = 5;
    localparam int         source_edge_bit   = 4;
    localparam int         prescaler_asg_bit = 3;
    localparam int         rate_lsb          = 0;
    localparam logic [1:0] write_inhibit_cyc = 2'h2;
    localparam logic [7:0] prescaler_rst     = 8'h00;
    localparam logic [1:0] phase_two         = 2'h1;
    localparam logic [1:0] phase_four        = 2'h3;

    typedef struct packed {
        logic       clock_source_select;
        logic       source_edge_select;
        logic       prescaler_assign;
        logic [2:0] prescale_rate;
    } timer_config_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } file_write_t;
endpackage

// ### rtl/timer_counter.sv
`timescale 1ns/10ps
module timer_counter (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // core side
    input  wire tmr_pkg::file_write_t file_wr,
    input  wire logic                 config_wr,
    input  wire logic [5:0]           config_data,
    input  wire logic                 watchdog_clear_instr,
    // external pin
    input  wire logic                 external_count_input,
    // outputs
    output logic [7:0]                timer_count_reg,
    output logic                      watchdog_postscale_out,
    output logic                      watchdog_clear_out
);
    // clk is the oscillator; four clocks form one instruction cycle
    tmr_pkg::timer_config_t cfg;
    logic [1:0] phase;
    logic       pin_s1;
    logic       pin_s2;
    logic [7:0] prescaler;
    logic       src_prev;
    logic       pre_out;
    logic       sampled;
    logic       sampled_prev;
    logic       sample_new;
    logic [1:0] inhibit;
    logic       count_wr;
    logic       edge_src;
    logic       src_event;
    logic       inc_tick;
    logic       tick_ok;
    logic [7:0] next_count;

    assign count_wr = file_wr.wr && file_wr.addr == tmr_pkg::timer_count_addr;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= tmr_pkg::timer_config_rst;
        end else if (config_wr) begin
            cfg <= config_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= external_count_input;
            pin_s2 <= pin_s1;
        end
    end

    // edge selection; falling edge becomes rising after inversion
    assign edge_src = cfg.clock_source_select
                      ? (pin_s2 ^ cfg.source_edge_select)
                      : phase[1];

    always_ff @(posedge clk or negedge rst_b) begin
        // idle level of the reset source is high; avoids a false edge
        if (!rst_b) begin
            src_prev <= 1'b1;
        end else begin
            src_prev <= edge_src;
        end
    end

    assign src_event = edge_src && !src_prev;

    // one shared counter; a clock-synchronous stand-in for the ripple chain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prescaler <= tmr_pkg::prescaler_rst;
        end else if (count_wr && !cfg.prescaler_assign) begin
            prescaler <= tmr_pkg::prescaler_rst;
        end else if (watchdog_clear_instr && cfg.prescaler_assign) begin
            prescaler <= tmr_pkg::prescaler_rst;
        end else if (src_event) begin
            prescaler <= prescaler + 8'h01;
        end
    end

    // timer output is a symmetric bit of the divider when prescaler_assign is low; the undivided edge source when high
    always_comb begin
        if (cfg.prescaler_assign) begin
            pre_out = edge_src;
        end else begin
            pre_out = prescaler[cfg.prescale_rate];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sampled      <= 1'b1;
            sampled_prev <= 1'b1;
        end else if (phase == tmr_pkg::phase_two
                     || phase == tmr_pkg::phase_four) begin
            sampled      <= pre_out;
            sampled_prev <= sampled;
        end
    end

    // marks the cycle right after a phase-two or phase-four sample
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sample_new <= 1'b0;
        end else begin
            sample_new <= phase == tmr_pkg::phase_two
                          || phase == tmr_pkg::phase_four;
        end
    end

    assign tick_ok  = phase == tmr_pkg::phase_four;
    assign inc_tick = sample_new && sampled && !sampled_prev;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inhibit <= 2'h0;
        end else if (count_wr) begin
            inhibit <= tmr_pkg::write_inhibit_cyc;
        end else if (tick_ok && inhibit != 2'h0) begin
            inhibit <= inhibit - 2'h1;
        end
    end

    always_comb begin
        next_count = timer_count_reg;
        if (count_wr) begin
            next_count = file_wr.data;
        end else if (inc_tick && inhibit == 2'h0) begin
            next_count = timer_count_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_count_reg <= 8'h00;
        end else begin
            timer_count_reg <= next_count;
        end
    end

    // watchdog side: postscaled tap and clear request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_postscale_out <= 1'b0;
            watchdog_clear_out     <= 1'b0;
        end else begin
            watchdog_postscale_out <= cfg.prescaler_assign
                                      && prescaler[cfg.prescale_rate];
            watchdog_clear_out     <= watchdog_clear_instr;
        end
    end
endmodule

// ### test/tc_checker.sv
`timescale 1ns/10ps
module tc_checker (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst_b,
    // watched ports
    input wire tmr_pkg::file_write_t file_wr,
    input wire logic                 config_wr,
    input wire logic [5:0]           config_data,
    input wire logic                 watchdog_clear_instr,
    input wire logic [7:0]           timer_count_reg,
    input wire logic                 watchdog_postscale_out
);
    logic [5:0] cfg;
    wire  [7:0] c = timer_count_reg;
    wire        wt = file_wr.wr && file_wr.addr == tmr_pkg::timer_count_addr;
    wire        q = !cfg[5] && cfg[3] && !file_wr.wr && !config_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b) cfg <= tmr_pkg::timer_config_rst;
        else if (config_wr) cfg <= config_data;
    a_wr_load: assert property (wt |=> c == $past(file_wr.data))
        else $error("count write lost");
    a_wr_hold: assert property (wt |=> ##1 (file_wr.wr || $stable(c))[*4])
        else $error("count moved in inhibit");
    a_step_wrap: assert property ($changed(c) && !$past(file_wr.wr)
        |-> c == $past(c) + 8'h01) else $error("bad count step");
    a_tick_gap: assert property ($changed(c) && !$past(file_wr.wr)
        |=> (file_wr.wr || $stable(c))[*3]) else $error("ticks too close");
    a_timer_rate: assert property (q[*8] ##1 q[*4]
        |-> c == $past(c, 4) + 8'h01) else $error("timer rate wrong");
    a_no_wd_tap: assert property ((!cfg[3])[*2] |-> !watchdog_postscale_out)
        else $error("tap active for timer");
    a_wd_clear: assert property (watchdog_clear_instr && cfg[3]
        |=> ##1 !watchdog_postscale_out) else $error("tap not cleared");
    a_rst_zero: assert property (disable iff (1'b0) !rst_b
        |-> c == 8'h00 && !watchdog_postscale_out) else $error("reset value");
endmodule
bind timer_counter tc_checker tc_checker_i (.*);

// ### test/ext_source.sv
`timescale 1ns/10ps
module ext_source #(parameter int half = 40) (
    // control and pin
    input  wire logic en,
    output logic      pin
);
    initial begin
        pin = 1'b0;
        #3;
        forever #(half) if (en) pin = !pin;
    end
endmodule

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic                 clk, rst_b, config_wr, watchdog_clear_instr, en, ext;
    logic                 wd_out, wd_clr;
    logic [5:0]           config_data;
    logic [7:0]           timer_count_reg;
    tmr_pkg::file_write_t file_wr;
    int                   miscompares, checked, cyc, rises, falls;
    timer_counter timer_counter_i (.clk(clk), .rst_b(rst_b), .file_wr(file_wr),
        .config_wr(config_wr), .config_data(config_data),
        .watchdog_clear_instr(watchdog_clear_instr),
        .external_count_input(ext), .timer_count_reg(timer_count_reg),
        .watchdog_postscale_out(wd_out), .watchdog_clear_out(wd_clr));
    ext_source ext_source_i (.en(en), .pin(ext));
    always #4 clk = !clk;
    always @(posedge ext) rises++;
    always @(negedge ext) falls++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        file_wr <= '{1'b1, tmr_pkg::timer_count_addr, d};
        @(posedge clk);
        file_wr.wr <= 1'b0;
    endtask
    task automatic cfg(input logic [5:0] c);
        @(posedge clk);
        config_wr <= 1'b1;
        config_data <= c;
        @(posedge clk);
        config_wr <= 1'b0;
    endtask
    task automatic wdclr();
        @(posedge clk);
        watchdog_clear_instr <= 1'b1;
        @(posedge clk);
        watchdog_clear_instr <= 1'b0;
    endtask
    task automatic chg(output int n);
        logic [7:0] v;
        v = timer_count_reg;
        n = 0;
        while (timer_count_reg === v && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic per(input logic [5:0] c, input int exp);
        int n;
        wdclr();
        cfg(c);
        wr(8'hff);
        @(negedge clk);
        chg(n);
        check(timer_count_reg, 8'h00);
        chg(n);
        check(n, exp);
    endtask
    task automatic ext_run(input logic [5:0] c, input int sh);
        logic [7:0] v;
        wdclr();
        wr(8'h00);
        cfg(c);
        repeat (12) @(negedge clk);
        v = timer_count_reg;
        rises = 0;
        falls = 0;
        en = 1'b1;
        repeat (100) @(negedge clk);
        en = 1'b0;
        repeat (12) @(negedge clk);
        check(timer_count_reg - v, (c[4] ? falls : rises) >> sh);
    endtask
    initial begin
        {clk, rst_b, config_wr, watchdog_clear_instr, en, config_data} = '0;
        file_wr = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        watchdog_clear_instr <= 1'b1;
        @(posedge clk);
        watchdog_clear_instr <= 1'b0;
        @(negedge clk);
        check(wd_clr, 1'b1);
        per(6'h08, 4);
        for (int r = 0; r < 8; r++)
            per(6'(r), 8 << r);
        ext_run(6'h28, 0);
        ext_run(6'h38, 0);
        ext_run(6'h20, 1);
        results();
    end
endmodule
